/* File: logic/tbtc_regs.svh */
`ifndef TBTC_REGS_SVH
`define TBTC_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define TBTC_CTRL_OFS 12'h000
`define TBTC_STAT_OFS 12'h004

// ---------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------
`define TBTC_ON_BIT 15
`define TBTC_STOP_IN_IDLE_BIT 13
`define TBTC_GATE_BIT 7
`define TBTC_PS_MSB 6
`define TBTC_PS_LSB 4
`define TBTC_WIDE_BIT 3
`define TBTC_SRC_BIT 1
`define TBTC_CTRL_RST 32'h0000_0000

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define TBTC_STAT_RUN_BIT 0
`define TBTC_STAT_GATE_BIT 1
`define TBTC_STAT_WIDE_BIT 2
`define TBTC_STAT_HALT_BIT 3

// ---------------------------------------------------------------
// Prescale limits (ratio minus one)
// ---------------------------------------------------------------
`define TBTC_PS_LIM_MAX 8'hff

`endif

/* File: logic/tbtc_pkg.sv */
`include "tbtc_regs.svh"
package tbtc_pkg;
  typedef enum logic [2:0] {
    TBTC_PS_1 = 3'h0,
    TBTC_PS_2 = 3'h1,
    TBTC_PS_4 = 3'h2,
    TBTC_PS_8 = 3'h3,
    TBTC_PS_16 = 3'h4,
    TBTC_PS_32 = 3'h5,
    TBTC_PS_64 = 3'h6,
    TBTC_PS_256 = 3'h7
  } tbtc_prescale_t;

  typedef enum logic {
    TBTC_SRC_INT = 1'b0,
    TBTC_SRC_EXT = 1'b1
  } tbtc_src_t;

  // Terminal count of the prescaler for a given code
  function automatic logic [7:0] tbtc_ps_limit(input tbtc_prescale_t ps);
    logic [7:0] lim;
    lim = 8'h00;
    if (ps == TBTC_PS_256) begin
      lim = `TBTC_PS_LIM_MAX;
    end else begin
      lim = 8'((9'h001 << ps) - 9'h001);
    end
    return lim;
  endfunction
endpackage

/* File: logic/tbtc_timer_control.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tbtc_regs.svh"

module tbtc_timer_control
  import tbtc_pkg::*;
#(
  parameter bit IS_EVEN = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic idle_mode_i,
  input wire logic ext_clk_i,
  input wire logic gate_i,
  input wire logic pair_wide_i,
  input wire logic pair_tick_i,
  output logic count_tick_o,
  output logic run_o,
  output logic pair_wide_o
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic [1:0] nxt_sync1;
  logic [1:0] nxt_sync2;

  assign pin_raw = {gate_i, ext_clk_i};

  // Only the second stage is read by the rest of the block
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_comb begin
        nxt_sync1[gi] = pin_raw[gi];
        nxt_sync2[gi] = sync1_ff[gi];
      end

      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
        end else begin
          sync1_ff[gi] <= nxt_sync1[gi];
          sync2_ff[gi] <= nxt_sync2[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // External edge detect
  // ---------------------------------------------------------------
  logic ext_prev_ff;
  logic nxt_ext_prev;
  logic ext_rise;
  logic gate_lvl;

  always_comb begin
    nxt_ext_prev = sync2_ff[0];
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= nxt_ext_prev;
    end
  end

  // Resets low like an idle pin: no false edge after reset
  assign ext_rise = sync2_ff[0] & ~ext_prev_ff;
  assign gate_lvl = sync2_ff[1];

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic on_ff;
  logic stop_in_idle_ff;
  logic gate_en_ff;
  tbtc_prescale_t ps_ff;
  logic wide_ff;
  tbtc_src_t src_ff;
  logic nxt_on;
  logic nxt_stop_in_idle;
  logic nxt_gate_en;
  tbtc_prescale_t nxt_ps;
  logic nxt_wide;
  tbtc_src_t nxt_src;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic [11:0] addr;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_en;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;

  assign addr = 12'(paddr_i);
  assign hit_ctrl = (addr == `TBTC_CTRL_OFS);
  assign hit_stat = (addr == `TBTC_STAT_OFS);
  assign wr_en = psel_i & penable_i & pwrite_i;

  // Zero wait states; bad addresses flagged in the access phase
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~(hit_ctrl | hit_stat);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------

  always_comb begin
    nxt_on = on_ff;
    nxt_stop_in_idle = stop_in_idle_ff;
    nxt_gate_en = gate_en_ff;
    nxt_ps = ps_ff;
    nxt_wide = wide_ff;
    nxt_src = src_ff;
    if (wr_en && hit_ctrl) begin
      if (pstrb_i[1]) begin
        nxt_on = pwdata_i[`TBTC_ON_BIT];
        nxt_stop_in_idle = pwdata_i[`TBTC_STOP_IN_IDLE_BIT];
      end
      if (pstrb_i[0]) begin
        nxt_gate_en = pwdata_i[`TBTC_GATE_BIT];
        nxt_ps = tbtc_prescale_t'(
          pwdata_i[`TBTC_PS_MSB:`TBTC_PS_LSB]);
        // Odd timers always load zero into their pairing flop
        nxt_wide = IS_EVEN & pwdata_i[`TBTC_WIDE_BIT];
        nxt_src = tbtc_src_t'(pwdata_i[`TBTC_SRC_BIT]);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      on_ff <= 1'b0;
      stop_in_idle_ff <= 1'b0;
      gate_en_ff <= 1'b0;
      ps_ff <= TBTC_PS_1;
      wide_ff <= 1'b0;
      src_ff <= TBTC_SRC_INT;
    end else begin
      on_ff <= nxt_on;
      stop_in_idle_ff <= nxt_stop_in_idle;
      gate_en_ff <= nxt_gate_en;
      ps_ff <= nxt_ps;
      wide_ff <= nxt_wide;
      src_ff <= nxt_src;
    end
  end

  // ---------------------------------------------------------------
  // Counting engine
  // ---------------------------------------------------------------
  logic wide_act;
  logic odd_slave;
  logic idle_halt;
  logic run;
  logic gated;
  logic src_tick;
  logic [7:0] ps_cnt_ff;
  logic [7:0] nxt_ps_cnt;
  logic tick_ff;
  logic nxt_tick;

  assign wide_act = IS_EVEN ? wide_ff : pair_wide_i;
  // Odd half of a pair just follows its even neighbour
  assign odd_slave = ~IS_EVEN & pair_wide_i;
  // Odd half still honours its own idle bit in a pair
  assign idle_halt = idle_mode_i & stop_in_idle_ff;
  assign run = on_ff & ~idle_halt;
  // Gating only applies to the internal source
  assign gated = gate_en_ff & (src_ff == TBTC_SRC_INT);

  // ---------------------------------------------------------------
  // Source tick
  // ---------------------------------------------------------------

  always_comb begin
    src_tick = 1'b1;
    if (src_ff == TBTC_SRC_EXT) begin
      src_tick = ext_rise;
    end else if (gated) begin
      src_tick = gate_lvl;
    end
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  logic [7:0] ps_lim;

  // Compare with >= so a smaller ratio takes effect at once
  assign ps_lim = tbtc_ps_limit(ps_ff);

  always_comb begin
    nxt_ps_cnt = ps_cnt_ff;
    nxt_tick = 1'b0;
    if (odd_slave) begin
      nxt_ps_cnt = 8'h00;
      nxt_tick = pair_tick_i & ~idle_halt;
    end else if (!on_ff) begin
      // Disabling restarts the prescaler from zero
      nxt_ps_cnt = 8'h00;
    end else if (run && src_tick) begin
      if (ps_cnt_ff >= ps_lim) begin
        nxt_ps_cnt = 8'h00;
        nxt_tick = 1'b1;
      end else begin
        nxt_ps_cnt = ps_cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ps_cnt_ff <= 8'h00;
      tick_ff <= 1'b0;
    end else begin
      ps_cnt_ff <= nxt_ps_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    ctrl_rd[`TBTC_ON_BIT] = on_ff;
    ctrl_rd[`TBTC_STOP_IN_IDLE_BIT] = stop_in_idle_ff;
    ctrl_rd[`TBTC_GATE_BIT] = gated;
    ctrl_rd[`TBTC_PS_MSB:`TBTC_PS_LSB] = ps_ff;
    ctrl_rd[`TBTC_WIDE_BIT] = wide_ff;
    ctrl_rd[`TBTC_SRC_BIT] = src_ff;
  end

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  always_comb begin
    stat_rd = 32'h0000_0000;
    stat_rd[`TBTC_STAT_RUN_BIT] = odd_slave ? ~idle_halt : run;
    stat_rd[`TBTC_STAT_GATE_BIT] = gate_lvl;
    stat_rd[`TBTC_STAT_WIDE_BIT] = wide_act;
    stat_rd[`TBTC_STAT_HALT_BIT] = idle_halt;
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------

  // Read data is latched in the setup cycle
  always_comb begin
    nxt_prdata = prdata_ff;
    if (psel_i && !penable_i && !pwrite_i) begin
      nxt_prdata = hit_ctrl ? ctrl_rd : (hit_stat ? stat_rd : 32'h0);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_ff <= 32'h0000_0000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign prdata_o = prdata_ff;
  assign count_tick_o = tick_ff;
  assign run_o = stat_rd[`TBTC_STAT_RUN_BIT];
  assign pair_wide_o = wide_act;

endmodule
`default_nettype wire

/* File: verification/tbtc_timer_control_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Timer control checker
// --------------------------------
module tbtc_chk #(
  parameter bit IS_EVEN = 1'b1,
  parameter int ADDR_W = 12
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [31:0] prdata_o,
  input wire logic idle_mode_i,
  input wire logic gate_i,
  input wire logic count_tick_o,
  input wire logic pair_wide_o
);
  logic [31:0] ctl_ff, nxt_ctl, lane;
  logic wr, rd, on, d1, d4, g1;
  assign wr = psel_i && penable_i && pwrite_i && paddr_i == '0;
  assign rd = psel_i && penable_i && !pwrite_i && paddr_i == '0;
  // Lanes 2 and 3 hold no control bits
  assign lane = {16'h0, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
  assign nxt_ctl = wr ? ((pwdata_i & 32'ha0fa & lane) | (ctl_ff & ~lane))
    : ctl_ff;
  assign on = ctl_ff[15] && !(idle_mode_i && ctl_ff[13]);
  assign d1 = on && ctl_ff[7:1] == 7'h00;
  assign d4 = on && ctl_ff[7:1] == 7'h10;
  assign g1 = on && ctl_ff[7:1] == 7'h40;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctl_ff <= 32'h0;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i || !IS_EVEN);
  property p_off; !ctl_ff[15] |=> !count_tick_o; endproperty
  a_off: assert property (p_off) else $error("tick while off");
  property p_idle; ctl_ff[13] && idle_mode_i |=> !count_tick_o; endproperty
  a_idle: assert property (p_idle) else $error("tick in idle");
  property p_div1; d1 |=> count_tick_o; endproperty
  a_div1: assert property (p_div1) else $error("1:1 tick missing");
  property p_div4;
    (count_tick_o && d4) ##1 d4 [*4] |-> count_tick_o && !$past(count_tick_o)
      && !$past(count_tick_o, 2) && !$past(count_tick_o, 3);
  endproperty
  a_div4: assert property (p_div4) else $error("1:4 spacing");
  property p_glo; (g1 && !gate_i) [*5] |=> !count_tick_o; endproperty
  a_glo: assert property (p_glo) else $error("tick gate low");
  property p_ghi; (g1 && gate_i) [*5] |=> count_tick_o; endproperty
  a_ghi: assert property (p_ghi) else $error("no tick gate high");
  property p_src; rd && ctl_ff[1] |-> !prdata_o[7]; endproperty
  a_src: assert property (p_src) else $error("gate bit read");
  property p_unim; rd |-> (prdata_o & 32'hffff5f05) == 32'h0; endproperty
  a_unim: assert property (p_unim) else $error("spare bits set");
  property p_wide; 1'b1 |-> pair_wide_o == ctl_ff[3]; endproperty
  a_wide: assert property (p_wide) else $error("wide mismatch");
endmodule
bind tbtc_timer_control tbtc_chk #(.IS_EVEN(IS_EVEN), .ADDR_W(ADDR_W)) chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
  .idle_mode_i(idle_mode_i), .gate_i(gate_i), .count_tick_o(count_tick_o),
  .pair_wide_o(pair_wide_o)
);
`default_nettype wire

/* File: verification/tbtc_timer_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------
// Timer control bench
// --------------------------------
module tbtc_timer_control_test;
  logic clk_i = 1'b0, resetn_i = 1'b0, psel_e = 1'b0, psel_od = 1'b0;
  logic penable = 1'b0, pwrite = 1'b0, idle = 1'b0, gate = 1'b0;
  logic ext_clk = 1'b0, ext_on = 1'b0, serr;
  logic rdy_e, rdy_o, err_e, tick_e, tick_o, wide_e;
  logic run_e, run_od, wide_od, hlt, run_x;
  logic [3:0] pstrb = 4'hf;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rdata, rd_e, rd_o;
  int num_errors = 0, n_compared = 0;
  logic [31:0] cnt_e, cnt_o;
  localparam logic [18:0] CS[6] = '{19'h00000, 19'h4a000, 19'h48000,
    19'h08080, 19'h28080, 19'h18082};
  localparam logic [31:0] EX[6] = '{32'h0, 32'h0, 32'h40, 32'h0, 32'h40,
    32'h20};
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) ext_clk <= ext_on ? !ext_clk : 1'b0;
  tbtc_timer_control #(.IS_EVEN(1'b1)) uut (.clk_i(clk_i),
    .resetn_i(resetn_i), .psel_i(psel_e), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(rd_e), .pready_o(rdy_e), .pslverr_o(err_e),
    .idle_mode_i(idle), .ext_clk_i(ext_clk), .gate_i(gate),
    .pair_wide_i(1'b0), .pair_tick_i(1'b0), .count_tick_o(tick_e),
    .run_o(run_e), .pair_wide_o(wide_e));
  tbtc_timer_control #(.IS_EVEN(1'b0)) uut_odd (.clk_i(clk_i),
    .resetn_i(resetn_i), .psel_i(psel_od), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(rd_o), .pready_o(rdy_o), .pslverr_o(),
    .idle_mode_i(idle), .ext_clk_i(ext_clk), .gate_i(gate),
    .pair_wide_i(wide_e), .pair_tick_i(tick_e), .count_tick_o(tick_o),
    .run_o(run_od), .pair_wide_o(wide_od));
  task automatic results;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic odd, input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    @(posedge clk_i);
    psel_e <= !odd;
    psel_od <= odd;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (!(odd ? rdy_o : rdy_e));
    rdata = odd ? rd_o : rd_e;
    serr = err_e;
    psel_e <= 1'b0;
    psel_od <= 1'b0;
    penable <= 1'b0; // Always an idle cycle after a transfer
  endtask
  // Settle first: pins pass a synchroniser before counting
  task automatic span(input int n);
    repeat (8) @(posedge clk_i);
    cnt_e = 0;
    cnt_o = 0;
    repeat (n) begin
      @(posedge clk_i);
      cnt_e += tick_e;
      cnt_o += tick_o;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    apb(0, 0, 12'h0, 32'h0);
    chk(rdata, 32'h0);
    apb(0, 1, 12'h0, 32'hffffffff);
    apb(0, 0, 12'h0, 32'h0);
    chk(rdata, 32'h0000a07a);
    pstrb <= 4'h1;
    apb(0, 1, 12'h0, 32'h0);
    apb(0, 0, 12'h0, 32'h0);
    chk(rdata, 32'h0000a000);
    pstrb <= 4'h2;
    apb(0, 1, 12'h0, 32'h0);
    apb(0, 0, 12'h0, 32'h0);
    chk(rdata, 32'h0);
    pstrb <= 4'hf;
    apb(0, 0, 12'h010, 32'h0);
    chk({31'h0, serr}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      apb(0, 1, 12'h0, 32'h8000 | 32'(i << 4));
      span(512);
      chk(cnt_e, 32'h200 >> (i == 7 ? 8 : i));
    end
    for (int i = 0; i < 6; i++) begin
      {idle, gate, ext_on} <= CS[i][18:16];
      apb(0, 1, 12'h0, {16'h0, CS[i][15:0]});
      span(64);
      chk(cnt_e, EX[i]);
      hlt = CS[i][18] && CS[i][13];
      run_x = CS[i][15] && !hlt;
      chk({31'h0, run_e}, {31'h0, run_x});
      apb(0, 0, 12'h004, 32'h0);
      chk(rdata, {28'h0, hlt, 1'b0, CS[i][17], run_x});
    end
    ext_on <= 1'b0;
    apb(1, 1, 12'h0, 32'hffffffff);
    apb(1, 0, 12'h0, 32'h0);
    chk(rdata, 32'h0000a072);
    apb(0, 1, 12'h0, 32'h8008);
    span(64);
    chk(cnt_o, 32'h40);
    chk({30'h0, wide_od, run_od}, 32'h3);
    idle <= 1'b1;
    span(64);
    chk(cnt_o, 32'h0);
    chk({30'h0, wide_od, run_od}, 32'h2);
    apb(1, 1, 12'h0, 32'h0);
    span(64);
    chk(cnt_o, 32'h40);
    chk({30'h0, wide_od, run_od}, 32'h3);
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    results();
  end
endmodule
`default_nettype wire
